// ### common/qpc_pkg.sv
// Summary of operation
// - index high at selected A/B phase reloads count from constant B unless bits 11:10 are 11; 000, 101-111 off
// - quadrature counts X1, X2 or X4 per bits 5:4; bit 6 enables B
// - quadrature interrupt stays pending until cleared; re-raised while condition persists
// - clock source 000-100 picks internal rates from carrier; 101 picks external clock
// - bits 11:10: none, count equals A, index with reload, index without reload
// - control bits 12 and 14 read zero in quadrature mode
// - bit 13 rejects pulses up to 2.5 us on A, B, index inputs
// - bit 15 enables interrupts; zero, the default, disables them
// - condition 01 drives output active while count equals constant A
// - condition bit 11 drives output active while index condition holds
// - mode 010 selects continuous pulse width modulation
// - constant A sets time before active, constant B the active width; polarity bit
// - at one (zero at the highest internal rate), toggle output, load other constant, keep counting down
// - a constant of N gives a phase of N selected clock cycles
// - highest internal clock rate adds one cycle to each phase
// - active-low gate counts while A is low, halts while high
// - active-high gate counts while A is high, halts while low
// - B is the clock only with bits 7:6 at 01/10 and source 101
// - PWM starts on software trigger write or external trigger input
// - with bit 15 set, every PWM toggle at a phase end raises an interrupt; leaving the idle level at start does not
package qpc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRIG = 8'h04;
  localparam logic [7:0] OFF_CONST_A = 8'h08;
  localparam logic [7:0] OFF_CONST_B = 8'h0C;
  localparam logic [7:0] OFF_READBACK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_AIN_LSB = 4;
  localparam int CTRL_BEN_BIT = 6;
  localparam int CTRL_BIN_LSB = 6;
  localparam int CTRL_PHASE_LSB = 7;
  localparam int CTRL_TRIG_LSB = 8;
  localparam int CTRL_ICOND_LSB = 10;
  localparam int CTRL_CLK_LSB = 10;
  localparam int CTRL_UNUSED12_BIT = 12;
  localparam int CTRL_DEB_BIT = 13;
  localparam int CTRL_UNUSED14_BIT = 14;
  localparam int CTRL_IEN_BIT = 15;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // status bits
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  // codes
  localparam logic [2:0] MODE_QUAD = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] CLK_MAX_INT = 3'h4;
  localparam logic [2:0] CLK_EXT = 3'h5;
  // timing
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DB_TIME_NS = 2500;
  localparam int DB_CYC = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_W = 9;
  localparam int BASE_KHZ = 500;
  localparam int ACC_W = 17;
  typedef enum logic [1:0] {ST_IDLE, ST_QUAD, ST_PWM} run_state_e;
endpackage

// ### hw/input_debounce.sv
module input_debounce (
  input wire logic clk_sys_i, // system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic raw_i, // raw input level
  input wire logic en_i, // filter enable
  output logic flt_o // filtered level
);
  import qpc_pkg::*;
  logic [DB_W-1:0] cnt_r;
  logic [DB_W-1:0] cnt_nxt;
  logic flt_r;
  logic flt_nxt;

  // a new level is taken only after it outlasts the reject window
  always_comb begin
    cnt_nxt = '0;
    flt_nxt = flt_r;
    if (!en_i) begin
      flt_nxt = raw_i;
    end else if (raw_i != flt_r) begin
      if (cnt_r == DB_W'(DB_CYC)) begin
        flt_nxt = raw_i;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      flt_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      flt_r <= flt_nxt;
    end
  end

  assign flt_o = flt_r;

  a_db_reject: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    en_i && $past(en_i) && $changed(flt_r) |-> $past(cnt_r) == DB_W'(DB_CYC))
    else $error("debounced level changed before window elapsed");
endmodule // input_debounce

// ### hw/quadrature_and_pwm_counter.sv
module quadrature_and_pwm_counter (
  input wire logic clk_sys_i, // 100 MHz system clock
  input wire logic sys_rst_i, // async reset, active high
  input wire logic [qpc_pkg::ADDR_W-1:0] addr_i, // register byte address
  input wire logic [qpc_pkg::DATA_W-1:0] wr_data_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [qpc_pkg::DATA_W-1:0] rd_data_o, // read data, cycle after rd_i
  input wire logic carrier_32mhz_i, // carrier runs at 32 MHz, else 8 MHz
  input wire logic first_phase_gate_input_i, // channel A / gate-off
  input wire logic second_phase_clock_input_i, // channel B / external clock
  input wire logic index_trigger_i, // index / external trigger
  output logic out_o, // counter output pin level
  output logic irq_o // interrupt pending
);
  import qpc_pkg::*;

  logic [2:0] raw_in;
  logic [2:0] flt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [CNT_W-1:0] ca_r;
  logic [CNT_W-1:0] ca_nxt;
  logic [CNT_W-1:0] cb_r;
  logic [CNT_W-1:0] cb_nxt;
  logic [2:0] prev_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic int_tick;
  logic [ACC_W:0] acc_sum;
  logic [ACC_W-1:0] step;
  logic [2:0] shamt;
  run_state_e state_r;
  run_state_e state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic phase_r;
  logic phase_nxt;
  logic out_r;
  logic out_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [15:0] rd_r;
  logic [15:0] rd_nxt;
  logic out_act;
  logic pend_set;

  assign raw_in = {index_trigger_i, second_phase_clock_input_i, first_phase_gate_input_i};

  // one filter per input, all steered by the same enable
  for (genvar gi = 0; gi < 3; gi++) begin : g_db
    input_debounce u_db (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .raw_i(raw_in[gi]),
      .en_i(ctrl_r[CTRL_DEB_BIT]),
      .flt_o(flt[gi])
    );
  end

  // control field decode
  logic [2:0] mode;
  logic pol;
  logic [1:0] ain;
  logic [1:0] bin;
  logic [2:0] psel;
  logic [1:0] tsel;
  logic [1:0] icond;
  logic [2:0] csel;
  logic ien;
  assign mode = ctrl_r[CTRL_MODE_LSB +: 3];
  assign pol = ctrl_r[CTRL_POL_BIT];
  assign ain = ctrl_r[CTRL_AIN_LSB +: 2];
  assign bin = ctrl_r[CTRL_BIN_LSB +: 2];
  assign psel = ctrl_r[CTRL_PHASE_LSB +: 3];
  assign tsel = ctrl_r[CTRL_TRIG_LSB +: 2];
  assign icond = ctrl_r[CTRL_ICOND_LSB +: 2];
  assign csel = ctrl_r[CTRL_CLK_LSB +: 3];
  assign ien = ctrl_r[CTRL_IEN_BIT];

  // filtered levels and edges; B is ignored in quadrature unless enabled
  logic a_in;
  logic b_in;
  logic idx_in;
  logic b_q;
  logic b_qp;
  logic a_rise;
  logic a_fall;
  logic b_edge;
  logic a_edge;
  assign a_in = flt[0];
  assign b_in = flt[1];
  assign idx_in = flt[2];
  assign b_q = b_in & ctrl_r[CTRL_BEN_BIT];
  assign b_qp = prev_r[1] & ctrl_r[CTRL_BEN_BIT];
  assign a_rise = a_in & ~prev_r[0];
  assign a_fall = ~a_in & prev_r[0];
  assign a_edge = a_rise | a_fall;
  assign b_edge = b_q ^ b_qp;

  // quadrature step decode
  logic inc;
  logic dec;
  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    case (ain)
      2'b01: begin
        inc = a_rise & ~b_q;
        dec = a_fall & ~b_q;
      end
      2'b10: begin
        inc = a_edge & (a_in ^ b_q);
        dec = a_edge & ~(a_in ^ b_q);
      end
      2'b11: begin
        inc = (a_edge & (a_in ^ b_q)) | (b_edge & ~(b_q ^ a_in));
        dec = (a_edge & ~(a_in ^ b_q)) | (b_edge & (b_q ^ a_in));
      end
      default: begin
        inc = 1'b0;
        dec = 1'b0;
      end
    endcase
  end

  // index phase match
  logic idx_cond;
  always_comb begin
    case (psel)
      3'h1: idx_cond = idx_in & ~a_in & b_q;
      3'h2: idx_cond = idx_in & a_in & ~b_q;
      3'h3: idx_cond = idx_in & a_in & b_q;
      3'h4: idx_cond = idx_in & ~a_in & ~b_q;
      default: idx_cond = 1'b0;
    endcase
  end

  logic eq_hit;
  logic idx_hit;
  logic reload;
  assign eq_hit = (icond == 2'b01) && (cnt_r == ca_r);
  assign idx_hit = icond[1] && idx_cond;
  assign reload = idx_cond && (icond != 2'b11);

  // external trigger edges and external clock edges
  logic trig_ext;
  logic ext_tick;
  logic gate_ok;
  logic pwm_tick;
  logic sw_trig;
  assign sw_trig = wr_i && (addr_i == OFF_TRIG);
  assign trig_ext = (tsel == 2'b01 && !idx_in && prev_r[2]) ||
                    (tsel == 2'b10 && idx_in && !prev_r[2]);
  assign ext_tick = (csel == CLK_EXT) &&
                    ((bin == 2'b01 && !b_in && prev_r[1]) ||
                     (bin == 2'b10 && b_in && !prev_r[1]));
  always_comb begin
    case (ain)
      2'b01: gate_ok = !a_in;
      2'b10: gate_ok = a_in;
      default: gate_ok = 1'b1;
    endcase
  end
  assign pwm_tick = gate_ok && (int_tick || ext_tick);

  // rate generator: fractional accumulator, exact for every internal rate
  assign shamt = csel + (carrier_32mhz_i ? 3'h2 : 3'h0);
  assign step = ACC_W'(BASE_KHZ) << shamt;
  assign acc_sum = {1'b0, acc_r} + {1'b0, step};
  always_comb begin
    int_tick = 1'b0;
    acc_nxt = acc_r;
    if (csel <= CLK_MAX_INT) begin
      if (acc_sum >= (ACC_W + 1)'(CLK_FREQ_KHZ)) begin
        int_tick = 1'b1;
        acc_nxt = ACC_W'(acc_sum - (ACC_W + 1)'(CLK_FREQ_KHZ));
      end else begin
        acc_nxt = acc_sum[ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r <= '0;
      prev_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      prev_r <= {idx_in, b_in, a_in};
    end
  end

  // register writes
  always_comb begin
    ctrl_nxt = ctrl_r;
    ca_nxt = ca_r;
    cb_nxt = cb_r;
    if (wr_i) begin
      case (addr_i)
        OFF_CTRL: ctrl_nxt = wr_data_i;
        OFF_CONST_A: ca_nxt = wr_data_i;
        OFF_CONST_B: cb_nxt = wr_data_i;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
  end

  // phase end: a constant of N lasts N ticks, one more at the top rate
  logic done;
  assign done = (csel == CLK_MAX_INT) ? (cnt_r == '0) : (cnt_r <= CNT_W'(1));

  // counter engine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    phase_nxt = phase_r;
    out_act = 1'b0;
    pend_set = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (sw_trig && mode == MODE_QUAD) begin
          state_nxt = ST_QUAD;
        end else if ((sw_trig || trig_ext) && mode == MODE_PWM) begin
          state_nxt = ST_PWM;
          cnt_nxt = ca_r;
          phase_nxt = 1'b0;
        end
      end
      ST_QUAD: begin
        if (reload) begin
          cnt_nxt = cb_r;
        end else if (inc && !dec) begin
          cnt_nxt = cnt_r + 1'b1;
        end else if (dec && !inc) begin
          cnt_nxt = cnt_r - 1'b1;
        end
        out_act = eq_hit || idx_hit;
        pend_set = eq_hit || idx_hit;
      end
      ST_PWM: begin
        if (pwm_tick) begin
          if (done) begin
            phase_nxt = !phase_r;
            cnt_nxt = phase_r ? ca_r : cb_r;
            pend_set = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        out_act = phase_nxt;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // a control write stops the engine so it restarts cleanly on a trigger
    if (wr_i && addr_i == OFF_CTRL) begin
      state_nxt = ST_IDLE;
      phase_nxt = 1'b0;
    end
  end

  // output level and pending flag; a new event beats a same-cycle clear
  logic clr;
  assign clr = wr_i && (addr_i == OFF_STATUS) && wr_data_i[STAT_PEND_BIT];
  // the level follows the next state, so a start shows the inactive level at once
  always_comb begin
    out_nxt = 1'b1;
    if (state_nxt != ST_IDLE) begin
      out_nxt = out_act ? pol : !pol;
    end
    pend_nxt = ien && ((pend_r && !clr) || pend_set);
  end

  // read mux; unused control bits are masked here rather than in storage
  logic [15:0] ctrl_rd;
  always_comb begin
    ctrl_rd = ctrl_r;
    ctrl_rd[CTRL_UNUSED14_BIT] = 1'b0;
    if (mode == MODE_QUAD) begin
      ctrl_rd[CTRL_UNUSED12_BIT] = 1'b0;
    end
    rd_nxt = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        OFF_CTRL: rd_nxt = ctrl_rd;
        OFF_CONST_A: rd_nxt = ca_r;
        OFF_CONST_B: rd_nxt = cb_r;
        OFF_READBACK: rd_nxt = cnt_r;
        OFF_STATUS: begin
          rd_nxt[STAT_PEND_BIT] = pend_r;
          rd_nxt[STAT_RUN_BIT] = (state_r != ST_IDLE);
        end
        default: rd_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RST;
      ca_r <= '0;
      cb_r <= '0;
      state_r <= ST_IDLE;
      cnt_r <= '0;
      phase_r <= 1'b0;
      out_r <= 1'b1;
      pend_r <= 1'b0;
      rd_r <= 16'h0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      ca_r <= ca_nxt;
      cb_r <= cb_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      phase_r <= phase_nxt;
      out_r <= out_nxt;
      pend_r <= pend_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign out_o = out_r;
  assign irq_o = pend_r;
  assign rd_data_o = rd_r;

  logic stay;
  assign stay = !(wr_i && addr_i == OFF_CTRL);

  sequence s_pwm_start;
    state_r == ST_IDLE && mode == MODE_PWM && sw_trig && stay;
  endsequence
  sequence s_loaded;
    state_r == ST_PWM && cnt_r == $past(ca_r) && out_r == !pol;
  endsequence

  a_pwm_start_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    s_pwm_start |=> s_loaded)
    else $error("pwm did not start from constant A");
  a_ctrl_mask_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    rd_i && addr_i == OFF_CTRL && mode == MODE_QUAD |=> rd_data_o[14] == 1'b0 &&
    rd_data_o[12] == 1'b0)
    else $error("unused control bits read nonzero");
  a_irq_gate_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !ien |=> !irq_o)
    else $error("interrupt pending while disabled");
  a_quad_eq_out: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_QUAD && icond == 2'b01 && cnt_r == ca_r && stay |=> out_o == $past(pol))
    else $error("output not active on count match");
  a_quad_idx_out: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_QUAD && icond[1] && idx_cond && stay |=> out_o == $past(pol))
    else $error("output not active on index");
  a_idx_reload: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_QUAD && idx_cond && icond != 2'b11 && stay |=> cnt_r == $past(cb_r))
    else $error("index did not reload constant B");
  a_quad_irq_set: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_QUAD && ien && (eq_hit || idx_hit) |=> irq_o)
    else $error("quadrature interrupt not raised");
  a_pwm_edge_irq: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $past(state_r) == ST_PWM && state_r == ST_PWM && ien && $changed(out_o) |-> irq_o)
    else $error("output transition without interrupt");
  a_pwm_toggle_load: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_PWM && stay && pwm_tick && done && !phase_r |=>
    phase_r && cnt_r == $past(cb_r) && out_o == $past(pol))
    else $error("toggle did not load constant B");
  a_pwm_gate_halt: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    state_r == ST_PWM && stay && !gate_ok |=> $stable(cnt_r) && $stable(phase_r))
    else $error("pwm counted while gated off");
endmodule // quadrature_and_pwm_counter

// ### test/quad_source_model.sv
module quad_source_model (
  input wire logic clk_sys_i, // system clock
  output logic a_o, // channel A or gate level
  output logic b_o, // channel B or external clock
  output logic idx_o // index or external trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph; // encoder position, {a,b} runs 00,10,11,01
  // lines start low, like an encoder parked at phase zero
  initial begin
    ph = 2'h0;
    a_o = 1'b0;
    b_o = 1'b0;
    idx_o = 1'b0;
  end
  // one edge per call; the gap lets the input filters settle first
  task automatic step(input bit fwd, input int gap);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    @(posedge clk_sys_i);
    a_o <= ph[1] ^ ph[0];
    b_o <= ph[1];
    repeat (gap) @(posedge clk_sys_i);
  endtask
  // clock stands still between bursts, it never runs free
  task automatic clock_b(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      b_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      b_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
    end
  endtask
  // plain level changes for gate and trigger use
  task automatic set_a(input logic v);
    @(posedge clk_sys_i);
    a_o <= v;
  endtask
  task automatic set_idx(input logic v);
    @(posedge clk_sys_i);
    idx_o <= v;
  endtask
  // noise pulse of w cycles on A
  task automatic glitch_a(input int w);
    @(posedge clk_sys_i);
    a_o <= ~a_o;
    repeat (w) @(posedge clk_sys_i);
    a_o <= ~a_o;
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule // quad_source_model

// ### test/quadrature_and_pwm_counter_test.sv
module quadrature_and_pwm_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import qpc_pkg::*;
  logic clk_sys_i, sys_rst_i, wr, rd, car32, out_o, irq_o, first_phase_gate_input, second_phase_clock_input, inc;
  logic [7:0] addr;
  logic [15:0] wdata, rd_data_o, got, base;
  int failures, tests_run, ticks;

  quadrature_and_pwm_counter dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data_o), .carrier_32mhz_i(car32),
    .first_phase_gate_input_i(first_phase_gate_input), .second_phase_clock_input_i(second_phase_clock_input), .index_trigger_i(inc),
    .out_o(out_o), .irq_o(irq_o));
  quad_source_model enc (.clk_sys_i(clk_sys_i), .a_o(first_phase_gate_input), .b_o(second_phase_clock_input), .idx_o(inc));

  // 100 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard, the whole run needs well under this many cycles
  always @(posedge clk_sys_i) begin
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      failures++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bus master: strobes one cycle, read data taken in the cycle after
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rd_data_o;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // constants first, then control, whose write idles the engine; one trigger starts each run
  task automatic start(input logic [15:0] c, input logic [15:0] a, input logic [15:0] b,
                       input bit sw);
    wr_reg(OFF_CONST_A, a);
    wr_reg(OFF_CONST_B, b);
    wr_reg(OFF_CTRL, c);
    if (sw) wr_reg(OFF_TRIG, 16'h0001);
    wait_cyc(3);
  endtask
  task automatic done(input string s);
    $display("test %s ends at %0t", s, $time);
  endtask

  task automatic test_reset;
    rd_reg(OFF_CTRL, got);
    check(got, CTRL_RST);
    check(16'(out_o), 16'h0001);
    check(16'(irq_o), 16'h0000);
    rd_reg(8'h1C, got);
    check(got, 16'h0000);
    rd_reg(OFF_TRIG, got);
    check(got, 16'h0000);
    wr_reg(OFF_CTRL, 16'hFFF9);
    rd_reg(OFF_CTRL, got);
    check(got, 16'hAFF9);
    done("reset");
  endtask
  // external clock on B rising, active high, interrupt on each edge
  task automatic test_pwm;
    start(16'h948A, 16'h0003, 16'h0002, 1);
    check(16'(out_o), 16'h0000);
    enc.clock_b(2);
    #1 check(16'(out_o), 16'h0000);
    enc.clock_b(1);
    #1 check(16'(out_o), 16'h0001);
    check(16'(irq_o), 16'h0001);
    wr_reg(OFF_STATUS, 16'h0001);
    #1 check(16'(irq_o), 16'h0000);
    enc.clock_b(1);
    #1 check(16'(out_o), 16'h0001);
    enc.clock_b(1);
    #1 check(16'(out_o), 16'h0000);
    check(16'(irq_o), 16'h0001);
    done("pwm");
  endtask
  task automatic test_gate;
    logic [15:0] cfg[3];
    logic blk;
    cfg = '{16'h140A, 16'h14CA, 16'h144A};
    for (int g = 1; g < 3; g++) begin
      blk = (g == 1);
      enc.set_a(blk);
      start(16'h148A | 16'(g << 4), 16'h0003, 16'h0003, 1);
      enc.clock_b(4);
      #1 check(16'(out_o), 16'h0000);
      enc.set_a(!blk);
      enc.clock_b(3);
      #1 check(16'(out_o), 16'h0001);
    end
    enc.set_a(1'b0);
    // only B codes 01 and 10 with source 101 make B the clock
    for (int i = 0; i < 3; i++) begin
      start(cfg[i], 16'h0001, 16'h0001, 1);
      enc.clock_b(3);
      #1 check(16'(out_o), 16'(i == 2));
    end
    done("gate");
  endtask
  task automatic test_trig;
    start(16'h968A, 16'h0002, 16'h0002, 0);
    enc.clock_b(3);
    #1 check(16'(out_o), 16'h0001);
    enc.set_idx(1'b1);
    wait_cyc(4);
    check(16'(out_o), 16'h0000);
    enc.clock_b(2);
    #1 check(16'(out_o), 16'h0001);
    enc.set_idx(1'b0);
    done("trigger");
  endtask
  // active phase length in system cycles; accumulator jitter allowed
  task automatic test_rates;
    logic [2:0] cs[4];
    bit c32[4];
    int cyc[4];
    int n;
    cs = '{3'h4, 3'h3, 3'h0, 3'h4};
    c32 = '{1'b0, 1'b0, 1'b1, 1'b1};
    cyc = '{50, 75, 150, 12};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      car32 <= c32[i];
      start(16'h000A | 16'(cs[i]) << 10, 16'h0003, 16'h0003, 1);
      n = 0;
      while (out_o !== 1'b1 && n < 400) @(posedge clk_sys_i) #1 n++;
      n = 0;
      while (out_o !== 1'b0 && n < 400) @(posedge clk_sys_i) #1 n++;
      check(16'(n >= cyc[i] - 2 && n <= cyc[i] + 2), 16'h0001);
    end
    car32 <= 1'b0;
    done("rates");
  endtask
  task automatic test_quad;
    logic [15:0] exp[4];
    exp = '{16'h0000, 16'h0002, 16'h0004, 16'h0008};
    for (int c = 0; c < 4; c++) begin
      start(16'h0041 | 16'(c << 4), 16'h0000, 16'h0000, 1);
      // a quadrature start keeps the count, so steps are judged from here
      rd_reg(OFF_READBACK, base);
      repeat (8) enc.step(1, 4);
      rd_reg(OFF_READBACK, got);
      check(got, base + exp[c]);
      repeat (8) enc.step(0, 4);
      rd_reg(OFF_READBACK, got);
      check(got, base);
    end
    done("quadrature");
  endtask
  // equality with constant A, active low output; A is set to the held count
  task automatic test_events;
    rd_reg(OFF_READBACK, base);
    start(16'h8471, base, 16'h0000, 1);
    check(16'(out_o), 16'h0000);
    check(16'(irq_o), 16'h0001);
    enc.step(1, 4);
    check(16'(out_o), 16'h0001);
    check(16'(irq_o), 16'h0001);
    wr_reg(OFF_STATUS, 16'h0001);
    #1 check(16'(irq_o), 16'h0000);
    enc.step(0, 4);
    wr_reg(OFF_STATUS, 16'h0001);
    wait_cyc(2);
    check(16'(irq_o), 16'h0001);
    start(16'h0471, base, 16'h0000, 1);
    check(16'(out_o), 16'h0000);
    check(16'(irq_o), 16'h0000);
    done("events");
  endtask
  // index at phase A=1 B=1: reload, no reload, and phase codes that disable
  task automatic test_index;
    logic [15:0] cfg[4];
    logic [15:0] lvl[4];
    cfg = '{16'h09F1, 16'h0DF1, 16'h0871, 16'h0AF1};
    lvl = '{16'h0000, 16'h0000, 16'h0001, 16'h0001};
    for (int i = 0; i < 4; i++) begin
      start(cfg[i], 16'h0000, 16'h0064, 1);
      rd_reg(OFF_READBACK, base);
      enc.set_idx(1'b1);
      repeat (2) enc.step(1, 4);
      rd_reg(OFF_READBACK, got);
      check(got, (i == 0) ? 16'h0064 : base + 16'h0002);
      check(16'(out_o), lvl[i]);
      enc.set_idx(1'b0);
      repeat (2) enc.step(1, 4);
    end
    done("index");
  endtask
  // filtering is enabled as advised for noisy encoder lines
  task automatic test_debounce;
    start(16'h2071, 16'h0000, 16'h0000, 1);
    rd_reg(OFF_READBACK, base);
    enc.glitch_a(250);
    rd_reg(OFF_READBACK, got);
    check(got, base);
    enc.step(1, 300);
    rd_reg(OFF_READBACK, got);
    check(got, base + 16'h0001);
    done("debounce");
  endtask

  // reset for three cycles, then the scenarios in turn
  initial begin
    sys_rst_i = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    car32 = 1'b0;
    ticks = 0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    test_reset;
    test_pwm;
    test_gate;
    test_trig;
    test_rates;
    test_quad;
    test_events;
    test_index;
    test_debounce;
    complete_run;
  end
endmodule // quadrature_and_pwm_counter_test
